//--- acq_trigger_monitor.sv
// port checker for the time-based acquisition trigger
// assumes it is bound onto time_based_acquisition_trigger
`default_nettype none
module acq_trigger_monitor
  import acq_trigger_pkg::*;
(
  // clock, reset and register port
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdData,
  // sample sources and outputs
  input wire logic [31:0] timeStamp,
  input wire logic [7:0]  digInput,
  input wire logic        pktValid,
  input wire logic [31:0] pktTimeStamp,
  input wire logic [7:0]  pktDigInput,
  input wire logic        acqEnabled,
  input wire logic        sampleTick
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic ctlWr;
  logic rateWr;
  assign ctlWr = regWrite && regAddr == ADDR_ACQ_CONTROL;
  assign rateWr = regWrite && regAddr == ADDR_RATE_COUNT;
  AST_RD_IDLE: assert property (
    !$past(regRead) |-> regRdData == 32'h0000_0000)
    else $error("read data not idle");
  AST_PKT_TICK: assert property (
    pktValid |-> $past(sampleTick))
    else $error("packet without period end");
  AST_PKT_EN: assert property (
    pktValid |-> $past(acqEnabled))
    else $error("packet while disabled");
  AST_PKT_DATA: assert property (
    pktValid |-> pktTimeStamp == $past(timeStamp)
      && pktDigInput == $past(digInput))
    else $error("packet data not sampled at period end");
  AST_TICK_GAP: assert property (
    sampleTick |=> !sampleTick [*8])
    else $error("period ends too close");
  AST_EN_RISE: assert property (
    $rose(acqEnabled) |-> $past(ctlWr && regWrData[0]))
    else $error("enable rose without write");
  AST_EN_OFF: assert property (
    ctlWr && !regWrData[0] |=> !acqEnabled)
    else $error("enable stayed after write of zero");
  AST_EN_FALL: assert property (
    $fell(acqEnabled) |-> pktValid || $past(ctlWr))
    else $error("enable fell without cause");
  AST_RATE_CLR: assert property (
    rateWr ##2 regRead && regAddr == ADDR_RATE_COUNT
      |=> regRdData <= 32'h0000_0001)
    else $error("rate counter not cleared");
  cover property (pktValid);
  cover property ($fell(acqEnabled) && pktValid);
  cover property (ctlWr && !regWrData[0] && acqEnabled);
endmodule
bind time_based_acquisition_trigger acq_trigger_monitor acq_trigger_monitor_i (
  .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .timeStamp(timeStamp), .digInput(digInput), .pktValid(pktValid),
  .pktTimeStamp(pktTimeStamp), .pktDigInput(pktDigInput),
  .acqEnabled(acqEnabled), .sampleTick(sampleTick));
`default_nettype wire

//--- acq_trigger_pkg.sv
// constants, field layouts and types of the time-based acquisition trigger
// assumes a 50 MHz system clock and a word-indexed register port
`default_nettype none
package acq_trigger_pkg;

  // register indices as seen on the register port
  localparam logic [7:0] ADDR_PERIOD_MULT   = 8'h1e;
  localparam logic [7:0] ADDR_RATE_COUNT    = 8'h1f;
  localparam logic [7:0] ADDR_PW_TRIG_TWO   = 8'h22;
  localparam logic [7:0] ADDR_PW_TRIG_THREE = 8'h23;
  localparam logic [7:0] ADDR_REQ_COUNT     = 8'h2b;
  localparam logic [7:0] ADDR_REMAIN_COUNT  = 8'h2c;
  localparam logic [7:0] ADDR_ACQ_CONTROL   = 8'h2d;

  // pulse-width trigger control fields
  localparam int PW_THR_LSB  = 16;
  localparam int PW_THR_MSB  = 31;
  localparam int PW_TYPE_LSB = 0;
  localparam int PW_TYPE_MSB = 1;

  // acquisition control fields
  localparam int ACQ_ENABLE_BIT = 0;
  localparam int ACQ_ARM_BIT    = 1;
  localparam int ACQ_CONT_BIT   = 2;
  localparam int ACQ_GO_BIT     = 3;
  localparam int ACQ_ENC_LSB    = 4;
  localparam int ACQ_ENC_MSB    = 7;

  // cleared word and all-ones remaining load for an unlimited run
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
  localparam logic [31:0] UNLIMITED_LOAD = 32'hffff_ffff;

  // timebase
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS       = 2000;
  localparam int TICK_CYCLES   =
    (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_WIDTH     = 7;
  localparam logic [PRE_WIDTH-1:0] PRE_LAST =
    PRE_WIDTH'(TICK_CYCLES - 1);

  typedef enum logic [1:0] {
    TRIG_NEVER   = 2'h0,
    TRIG_GREATER = 2'h1,
    TRIG_LESS_EQ = 2'h2
  } trig_mode_type;

  // gray order along idle -> armed -> running
  typedef enum logic [1:0] {
    PH_IDLE    = 2'h0,
    PH_ARMED   = 2'h1,
    PH_RUNNING = 2'h3
  } phase_type;

endpackage
`default_nettype wire

//--- time_based_acquisition_trigger.sv
// time-based acquisition trigger: timebase, triggers, counters, packets
// assumes all inputs synchronous to clk_sys; packet sink always accepts
`default_nettype none

// Overview of operation
// - channel three threshold in bits 31..16
// - type 00 never, 01 greater, 10 less-equal
// - channel two has same type field
// - pulse-width hit starts sampling in one stage
// - compare only low 16 measurement bits
// - sample period is (multiplier+1) times 2 us
// - capture only after arm then go
// - rate counter advances each sample period
// - a write to the rate counter address clears it
// - arm event clears rate counter
// - requested count zero means unlimited
// - each sample pushes a full packet
// - arm loads remaining from requested
// - remaining decrements each period after go
// - remaining at zero clears enable, stops
// - zero request loads all ones, no decrement
// - control register enables and reports status
// - four trigger sources are ORed together
// - enable 0 resets triggers, status, remaining
// - go status needs arm first
// - single-stage event sets arm and go
module time_based_acquisition_trigger
  import acq_trigger_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // register port
  input  wire logic [7:0]             regAddr,
  input  wire logic [31:0]            regWrData,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic      [31:0]            regRdData,
  // trigger sources
  input  wire logic                   digArmEvent,
  input  wire logic                   digGoEvent,
  input  wire logic                   adcTrigEvent,
  input  wire logic [3:0]             encEvent,
  input  wire logic [31:0]            pulseWidthTwo,
  input  wire logic [31:0]            pulseWidthThree,
  // live sample sources
  input  wire logic [31:0]            timeStamp,
  input  wire logic [3:0][23:0]       encCount,
  input  wire logic [3:0][7:0]        encStatus,
  input  wire logic [7:0]             digInput,
  input  wire logic [3:0][11:0]       adcValue,
  // packet to the streaming fifo
  output logic                        pktValid,
  output logic      [31:0]            pktTimeStamp,
  output logic      [3:0][23:0]       pktEncCount,
  output logic      [3:0][7:0]        pktEncStatus,
  output logic      [7:0]             pktDigInput,
  output logic      [3:0][11:0]       pktAdcValue,
  // enable status level and one-cycle period-end strobe
  output logic                        acqEnabled,
  output logic                        sampleTick
);

  typedef struct packed {
    logic [PRE_WIDTH-1:0] preCnt;
    logic [31:0]          perCnt;
    logic [31:0]          mult;
    logic [31:0]          rateCnt;
    logic [15:0]          thrTwo;
    logic [1:0]           modeTwo;
    logic [15:0]          thrThree;
    logic [1:0]           modeThree;
    logic [31:0]          reqCount;
    logic [31:0]          remain;
    logic                 unlimited;
    logic                 enable;
    logic [3:0]           encEn;
    phase_type            phase;
    logic [31:0]          rdData;
    logic                 pktValid;
    logic [31:0]          pktTime;
    logic [3:0][23:0]     pktCount;
    logic [3:0][7:0]      pktStatus;
    logic [7:0]           pktDin;
    logic [3:0][11:0]     pktAdc;
  } state_type;

  state_type q;
  state_type d;

  // threshold compare on the low half of the measurement
  function automatic logic pw_hit(input logic [1:0]  mode,
                                  input logic [15:0] thr,
                                  input logic [31:0] meas);
    logic hit;
    hit = 1'b0;
    case (mode)
      TRIG_GREATER: hit = meas[15:0] > thr;
      TRIG_LESS_EQ: hit = meas[15:0] <= thr;
      default:      hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic tick;
  logic periodEnd;
  logic singleHit;
  logic armHit;
  logic goHit;

  always_comb begin
    d = q;
    d.pktValid = 1'b0;

    // 2 us timebase and sample period divider
    tick = q.preCnt == PRE_LAST;
    d.preCnt = tick ? '0 : q.preCnt + PRE_WIDTH'(1);
    periodEnd = tick && (q.perCnt == q.mult);
    if (tick) begin
      d.perCnt = periodEnd ? RESET_WORD : q.perCnt + 32'h0000_0001;
    end
    if (periodEnd) begin
      d.rateCnt = q.rateCnt + 32'h0000_0001;
    end

    // trigger sources
    singleHit = adcTrigEvent
              | pw_hit(q.modeTwo, q.thrTwo, pulseWidthTwo)
              | pw_hit(q.modeThree, q.thrThree,
                       pulseWidthThree)
              | (|(encEvent & q.encEn));
    armHit = q.enable && (q.phase == PH_IDLE)
             && (digArmEvent || singleHit);
    goHit  = q.enable
             && (((q.phase == PH_ARMED) && digGoEvent)
                 || ((q.phase == PH_IDLE) && singleHit));

    if (armHit) begin
      d.phase = PH_ARMED;
      d.rateCnt = RESET_WORD;
      d.unlimited = q.reqCount == RESET_WORD;
      d.remain = (q.reqCount == RESET_WORD) ? UNLIMITED_LOAD
                                            : q.reqCount;
    end
    if (goHit) begin
      d.phase = PH_RUNNING;
    end

    // sampling after arm then go
    if (q.enable && (q.phase == PH_RUNNING) && periodEnd) begin
      d.pktValid  = 1'b1;
      d.pktTime   = timeStamp;
      d.pktCount  = encCount;
      d.pktStatus = encStatus;
      d.pktDin    = digInput;
      d.pktAdc    = adcValue;
      if (!q.unlimited) begin
        d.remain = q.remain - 32'h0000_0001;
        if (q.remain == 32'h0000_0001) begin
          d.enable = 1'b0;
          d.phase  = PH_IDLE;
        end
      end
    end

    // register writes
    if (regWrite) begin
      case (regAddr)
        ADDR_PERIOD_MULT: d.mult = regWrData;
        ADDR_RATE_COUNT:  d.rateCnt = RESET_WORD;
        ADDR_PW_TRIG_TWO: begin
          d.thrTwo  = regWrData[PW_THR_MSB:PW_THR_LSB];
          d.modeTwo = regWrData[PW_TYPE_MSB:PW_TYPE_LSB];
        end
        ADDR_PW_TRIG_THREE: begin
          d.thrThree  = regWrData[PW_THR_MSB:PW_THR_LSB];
          d.modeThree = regWrData[PW_TYPE_MSB:PW_TYPE_LSB];
        end
        ADDR_REQ_COUNT: d.reqCount = regWrData;
        ADDR_ACQ_CONTROL: begin
          d.encEn  = regWrData[ACQ_ENC_MSB:ACQ_ENC_LSB];
          d.enable = regWrData[ACQ_ENABLE_BIT];
          if (!regWrData[ACQ_ENABLE_BIT]) begin
            d.phase     = PH_IDLE;
            d.remain    = RESET_WORD;
            d.unlimited = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // register reads, answered in the next cycle
    d.rdData = RESET_WORD;
    if (regRead) begin
      case (regAddr)
        ADDR_PERIOD_MULT:  d.rdData = q.mult;
        ADDR_RATE_COUNT:   d.rdData = q.rateCnt;
        ADDR_PW_TRIG_TWO:  d.rdData = {q.thrTwo, 14'h0000, q.modeTwo};
        ADDR_PW_TRIG_THREE:
          d.rdData = {q.thrThree, 14'h0000, q.modeThree};
        ADDR_REQ_COUNT:    d.rdData = q.reqCount;
        ADDR_REMAIN_COUNT: d.rdData = q.remain;
        ADDR_ACQ_CONTROL: begin
          d.rdData[ACQ_ENC_MSB:ACQ_ENC_LSB] = q.encEn;
          d.rdData[ACQ_GO_BIT]     = q.phase == PH_RUNNING;
          d.rdData[ACQ_CONT_BIT]   = (q.phase == PH_RUNNING)
                                     && q.unlimited;
          d.rdData[ACQ_ARM_BIT]    = q.phase != PH_IDLE;
          d.rdData[ACQ_ENABLE_BIT] = q.enable;
        end
        default: d.rdData = RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign regRdData    = q.rdData;
  assign pktValid     = q.pktValid;
  assign pktTimeStamp = q.pktTime;
  assign pktEncCount  = q.pktCount;
  assign pktEncStatus = q.pktStatus;
  assign pktDigInput  = q.pktDin;
  assign pktAdcValue  = q.pktAdc;
  assign acqEnabled   = q.enable;
  assign sampleTick   = tick && (q.perCnt == q.mult);

endmodule
`default_nettype wire

//--- time_based_acquisition_trigger_tb.sv
// self-checking bench for the time-based acquisition trigger
// assumes the monitor file is compiled beside it
`default_nettype none
module time_based_acquisition_trigger_tb
  import acq_trigger_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst, regWrite, regRead, pktValid, acqEnabled;
  logic        digArmEvent, digGoEvent, adcTrigEvent, sampleTick;
  logic [7:0]  regAddr, digInput;
  logic [31:0] regWrData, regRdData, pulseWidthTwo, pulseWidthThree;
  logic [31:0] timeStamp, v;
  logic [3:0]        encEvent;
  logic [3:0][23:0]  encCount, pktEncCount;
  logic [3:0][7:0]   encStatus, pktEncStatus;
  logic [3:0][11:0]  adcValue, pktAdcValue;
  int          nMismatch, checksDone, cyc, nPkt, p;

  time_based_acquisition_trigger time_based_acquisition_trigger_i (
    .clk_sys, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .digArmEvent, .digGoEvent, .adcTrigEvent, .encEvent,
    .pulseWidthTwo, .pulseWidthThree, .timeStamp, .encCount,
    .encStatus, .digInput, .adcValue, .pktValid,
    .pktTimeStamp(), .pktEncCount, .pktEncStatus, .pktDigInput(),
    .pktAdcValue, .acqEnabled, .sampleTick);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    timeStamp <= timeStamp + 32'h0000_0001;
    digInput <= digInput + 8'h01;
    if (pktValid === 1'b1) nPkt <= nPkt + 1;
    if (cyc == 20000) begin
      nMismatch++;
      close_out();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 d = regRdData;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, string nm);
    rd(a, v);
    check(nm, v, e);
  endtask

  // k selects arm, go or analogue event for one cycle
  task automatic pulse(input int k);
    {digArmEvent, digGoEvent, adcTrigEvent} <= 3'h4 >> k;
    @(posedge clk_sys);
    {digArmEvent, digGoEvent, adcTrigEvent} <= 3'h0;
    @(posedge clk_sys);
  endtask

  task automatic t_regs;
    wr(ADDR_PW_TRIG_THREE, 32'hffff_ffff);
    rdc(ADDR_PW_TRIG_THREE, 32'hffff_0003, "pw3");
    wr(ADDR_PW_TRIG_TWO, 32'h0000_0001);
    rdc(ADDR_PW_TRIG_TWO, 32'h0000_0001, "pw2");
    wr(ADDR_PERIOD_MULT, 32'h1234_5678);
    rdc(ADDR_PERIOD_MULT, 32'h1234_5678, "mult");
    wr(ADDR_REMAIN_COUNT, 32'h0000_0005);
    rdc(ADDR_REMAIN_COUNT, 32'h0000_0000, "remainRo");
    rdc(8'h00, 32'h0000_0000, "unmapped");
    wr(ADDR_PW_TRIG_THREE, 32'h0000_0000);
    wr(ADDR_PERIOD_MULT, 32'h0000_0001);
  endtask

  task automatic t_limited;
    wr(ADDR_REQ_COUNT, 32'h0000_0002);
    rdc(ADDR_REQ_COUNT, 32'h0000_0002, "req");
    pulse(0);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_0000, "ignored");
    wr(ADDR_ACQ_CONTROL, 32'h0000_0001);
    pulse(1);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_0001, "goFirst");
    pulse(0);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_0003, "armed");
    rdc(ADDR_REMAIN_COUNT, 32'h0000_0002, "loaded");
    rd(ADDR_RATE_COUNT, v);
    check("rateArm", 32'(v <= 32'h1), 32'h1);
    p = nPkt;
    repeat (450) @(posedge clk_sys);
    check("noGo", p - nPkt, 0);
    pulse(1);
    repeat (600) @(posedge clk_sys);
    check("count", nPkt - p, 2);
    check("stopped", 32'(acqEnabled), 32'h0);
    rdc(ADDR_REMAIN_COUNT, 32'h0000_0000, "drained");
    rd(ADDR_RATE_COUNT, v);
    check("rateRun", 32'(v >= 32'h4 && v <= 32'h7), 32'h1);
  endtask

  task automatic t_cont;
    wr(ADDR_REQ_COUNT, 32'h0000_0000);
    wr(ADDR_ACQ_CONTROL, 32'h0000_0001);
    pulse(2);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_000f, "single");
    p = nPkt;
    repeat (500) @(posedge clk_sys);
    rdc(ADDR_REMAIN_COUNT, 32'hffff_ffff, "unlimited");
    check("contPkts", 32'(nPkt - p >= 2), 32'h1);
    wr(ADDR_ACQ_CONTROL, 32'h0000_0000);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_0000, "off");
    rdc(ADDR_REMAIN_COUNT, 32'h0000_0000, "offRemain");
    wr(ADDR_RATE_COUNT, 32'hdead_beef);
    rd(ADDR_RATE_COUNT, v);
    check("rateClr", 32'(v <= 32'h1), 32'h1);
  endtask

  task automatic t_pw;
    wr(ADDR_ACQ_CONTROL, 32'h0000_0001);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_0001, "pwNever");
    wr(ADDR_PW_TRIG_THREE, 32'h0010_0001);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_0001, "pwGtLow");
    wr(ADDR_PW_TRIG_THREE, 32'h000f_0001);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_000f, "pwGt");
    wr(ADDR_ACQ_CONTROL, 32'h0000_0000);
    wr(ADDR_PW_TRIG_THREE, 32'h0010_0002);
    wr(ADDR_ACQ_CONTROL, 32'h0000_0001);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_000f, "pwLe");
    wr(ADDR_ACQ_CONTROL, 32'h0000_0000);
  endtask

  // gated encoder events, one-sample run, packet contents, channel two
  task automatic t_enc;
    wr(ADDR_PW_TRIG_THREE, 32'h0000_0000);
    wr(ADDR_REQ_COUNT, 32'h0000_0001);
    wr(ADDR_ACQ_CONTROL, 32'h0000_0011);
    encEvent <= 4'h2;
    @(posedge clk_sys);
    encEvent <= 4'h0;
    @(posedge clk_sys);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_0011, "encGated");
    p = nPkt;
    encEvent <= 4'h1;
    @(posedge clk_sys);
    encEvent <= 4'h0;
    @(posedge clk_sys);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_001b, "encHit");
    repeat (450) @(posedge clk_sys);
    check("encPkts", nPkt - p, 1);
    check("pktEnc", 32'(pktEncCount[3]), 32'h0012_3456);
    check("pktStat", pktEncStatus, 32'ha5a5_a5a5);
    check("pktAdc", 32'(pktAdcValue[2]), 32'h0000_05a5);
    pulseWidthTwo <= 32'h0000_0001;
    wr(ADDR_ACQ_CONTROL, 32'h0000_0001);
    rdc(ADDR_ACQ_CONTROL, 32'h0000_000b, "pw2Gt");
    wr(ADDR_ACQ_CONTROL, 32'h0000_0000);
    pulseWidthTwo <= 32'h0000_0000;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {rst, regWrite, regRead, digArmEvent, digGoEvent, adcTrigEvent} = 6'h20;
    {regAddr, digInput, regWrData, timeStamp} = 80'h0;
    pulseWidthTwo = 32'h0000_0000;
    pulseWidthThree = 32'h0001_0010;
    encEvent = 4'h0;
    encCount = {4{24'h12_3456}};
    encStatus = {4{8'ha5}};
    adcValue = {4{12'h5a5}};
    {nMismatch, checksDone, cyc, nPkt} = 128'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_limited();
    t_cont();
    t_pw();
    t_enc();
    close_out();
  end
endmodule
`default_nettype wire
